/* File: common/dma_pkg.sv */
// Purpose: Shared constants and types for the two-channel SFR/RAM transfer engine.
// Assumes: Register indices are word indices; the APB byte address is four times the index.
// Notes: The register indices and address bases of the engine live here.
package dma_pkg;
  localparam int ADDR_W = 22;
  localparam int CH_N = 2;
  localparam int COUNT_W = 10;
  localparam int IDX_W = 20;
  // Register indices.
  localparam logic [19:0] IDX_SFR0 = 20'hFFFB0;
  localparam logic [19:0] IDX_SFR1 = 20'hFFFB1;
  localparam logic [19:0] IDX_RAM0 = 20'hFFFB2;
  localparam logic [19:0] IDX_RAM1 = 20'hFFFB4;
  localparam logic [19:0] IDX_CNT0 = 20'hFFFB6;
  localparam logic [19:0] IDX_CNT1 = 20'hFFFB8;
  localparam logic [19:0] IDX_MODE0 = 20'hFFFBA;
  localparam logic [19:0] IDX_MODE1 = 20'hFFFBB;
  localparam logic [19:0] IDX_OP0 = 20'hFFFBC;
  localparam logic [19:0] IDX_OP1 = 20'hFFFBD;
  // Mode register fields.
  localparam int MODE_TRIG = 7;
  localparam int MODE_DIR = 6;
  localparam int MODE_SIZE = 5;
  localparam int MODE_HOLD = 4;
  // Operation register fields.
  localparam int OP_EN = 7;
  localparam int OP_PEND = 0;
  // Reset values.
  localparam logic [7:0] SFR_RST = 8'h00;
  localparam logic [15:0] RAM_RST = 16'h0000;
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam logic [3:0] SRC_RST = 4'h0;
  // Fixed upper address bits.
  localparam logic [11:0] SFR_BASE = 12'hFFF;
  localparam logic [3:0] RAM_BASE = 4'hF;
  // Valid peripheral source codes, last count value and RAM address steps.
  localparam logic [3:0] SRC_MIN = 4'h2;
  localparam logic [3:0] SRC_MAX = 4'hC;
  localparam logic [9:0] CNT_LAST = 10'h001;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11
  } xfer_state_e;
endpackage : dma_pkg

/* File: core/sfr_ram_dma.sv */
// Purpose: Two-channel engine moving items between a fixed SFR and incrementing RAM.
// Assumes: APB4 slave with one wait state; memory answers reads in the same cycle.
// Notes: The CPU is stalled while an item moves.
//   Writes that would disturb a pending run are dropped without a bus error,
//   so software clears the pending flag before it reprograms a channel.
`timescale 1ns/1ns
module sfr_ram_dma (
  input wire logic ref_clk_in, // 10 MHz clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic psel_in, // APB select.
  input wire logic penable_in, // APB enable.
  input wire logic pwrite_in, // APB direction, high for write.
  input wire logic [dma_pkg::ADDR_W-1:0] paddr_in, // APB byte address.
  input wire logic [31:0] pwdata_in, // APB write data.
  input wire logic [3:0] pstrb_in, // APB byte strobes.
  output logic [31:0] prdata_out, // APB read data.
  output logic pready_out, // APB ready.
  output logic pslverr_out, // APB error on unmapped address.
  input wire logic [15:0] trig_vec_in, // Peripheral interrupt pulses by code.
  output logic [19:0] mem_addr_out, // Memory address.
  output logic mem_read_out, // Memory read cycle.
  output logic mem_write_out, // Memory write cycle.
  output logic mem_wide_out, // High for a 16-bit item.
  output logic [15:0] mem_wdata_out, // Memory write data.
  input wire logic [15:0] mem_rdata_in, // Memory read data.
  output logic cpu_stall_out, // Holds the CPU while an item moves.
  output logic [1:0] done_irq_out // Per-channel completion pulse.
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: the access acknowledge and the word index of the request.
  logic ack;
  logic hit;
  logic wr;
  logic [dma_pkg::IDX_W-1:0] idx;
  logic [31:0] next_rdata;
  // Per-channel programming state, one entry per channel.
  logic [7:0] sfr_address_reg [dma_pkg::CH_N];
  logic [15:0] ram_address_reg [dma_pkg::CH_N];
  logic [9:0] transfer_count_reg [dma_pkg::CH_N];
  logic [dma_pkg::CH_N-1:0] direction_select;
  logic [dma_pkg::CH_N-1:0] item_size_select;
  logic [dma_pkg::CH_N-1:0] hold_select;
  logic [3:0] trigger_source_select [dma_pkg::CH_N];
  logic [dma_pkg::CH_N-1:0] channel_enable_flag;
  logic [dma_pkg::CH_N-1:0] transfer_pending_flag;
  // Request bookkeeping; ready means the channel could be granted now.
  logic [dma_pkg::CH_N-1:0] req;
  logic [dma_pkg::CH_N-1:0] ready;
  logic [dma_pkg::CH_N-1:0] software_trigger;
  // Sequencer state shared by both channels; one item is in flight at most.
  logic cur;
  logic winner; // Channel that a grant in this cycle serves.
  logic [15:0] item_data;
  dma_pkg::xfer_state_e state;
  logic item_end;
  logic grant;

  // Registers are word-indexed, so the two byte-select bits are dropped.
  assign idx = paddr_in[dma_pkg::ADDR_W-1:2];
  // A write lands only at the edge where ready is high.
  assign wr = psel_in & penable_in & ack & pwrite_in;
  assign pready_out = ack;
  // The write cycle closes an item; counters step at its closing edge.
  assign item_end = (state == dma_pkg::ST_WRITE);
  // Grants are given only while no item is in flight, so items stay atomic.
  assign grant = (state == dma_pkg::ST_IDLE) & (|ready);
  // Channel 0 wins whenever both channels are ready in the same cycle.
  assign winner = ready[0] ? 1'b0 : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // One wait state lets read data come from a flip-flop.
  // The acknowledge drops after one cycle, so a master that holds its
  // request longer sees ready again every second cycle.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= psel_in & penable_in & ~ack;
    end
  end

  // Read data is captured in the first access cycle and stands with ready.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in & penable_in & ~ack) begin
      prdata_out <= next_rdata;
    end
  end

  // The error flag is a pulse that stands only with ready.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pslverr_out <= 1'b0;
    end else if (psel_in & penable_in & ~ack) begin
      pslverr_out <= ~hit;
    end else begin
      pslverr_out <= 1'b0;
    end
  end

  // Read multiplexer; the trigger bit always reads zero.
  // Unused upper bits read as zero, so software sees a clean count and a
  // clean SFR byte; an unknown index answers with an error.
  always_comb begin
    hit = 1'b1;
    next_rdata = 32'h00000000;
    case (idx)
      // Address registers.
      dma_pkg::IDX_SFR0: next_rdata[7:0] = sfr_address_reg[0];
      dma_pkg::IDX_SFR1: next_rdata[7:0] = sfr_address_reg[1];
      dma_pkg::IDX_RAM0: next_rdata[15:0] = ram_address_reg[0];
      dma_pkg::IDX_RAM1: next_rdata[15:0] = ram_address_reg[1];
      // Count registers; bits above the count read as zero.
      dma_pkg::IDX_CNT0: next_rdata[9:0] = transfer_count_reg[0];
      dma_pkg::IDX_CNT1: next_rdata[9:0] = transfer_count_reg[1];
      // Mode registers.
      dma_pkg::IDX_MODE0: next_rdata[7:0] = {1'b0, direction_select[0], item_size_select[0],
                                             hold_select[0], trigger_source_select[0]};
      dma_pkg::IDX_MODE1: next_rdata[7:0] = {1'b0, direction_select[1], item_size_select[1],
                                             hold_select[1], trigger_source_select[1]};
      // Operation registers.
      dma_pkg::IDX_OP0: next_rdata[7:0] = {channel_enable_flag[0], 6'h00,
                                           transfer_pending_flag[0]};
      dma_pkg::IDX_OP1: next_rdata[7:0] = {channel_enable_flag[1], 6'h00,
                                           transfer_pending_flag[1]};
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel registers; channel 1 indices are selected by the loop variable.
  // Each channel owns its registers outright; only the sequencer is shared.
  for (genvar ch = 0; ch < dma_pkg::CH_N; ch++) begin : g_ch
    localparam logic [19:0] I_SFR = (ch == 0) ? dma_pkg::IDX_SFR0 : dma_pkg::IDX_SFR1;
    localparam logic [19:0] I_RAM = (ch == 0) ? dma_pkg::IDX_RAM0 : dma_pkg::IDX_RAM1;
    localparam logic [19:0] I_CNT = (ch == 0) ? dma_pkg::IDX_CNT0 : dma_pkg::IDX_CNT1;
    localparam logic [19:0] I_MODE = (ch == 0) ? dma_pkg::IDX_MODE0 : dma_pkg::IDX_MODE1;
    localparam logic [19:0] I_OP = (ch == 0) ? dma_pkg::IDX_OP0 : dma_pkg::IDX_OP1;
    localparam logic CH_BIT = 1'(ch); // Channel number as a one-bit select.
    logic mine;
    logic last;
    logic periph;
    logic trig;
    logic served;
    logic [3:0] src;

    // This channel's item is in its write cycle.
    assign mine = item_end & (cur == CH_BIT);
    // The item that brings the count from one to zero ends the run.
    assign last = mine & (transfer_count_reg[ch] == dma_pkg::CNT_LAST);
    // The grant in this cycle consumes this channel's latched request.
    assign served = grant & (winner == CH_BIT);
    // Codes outside the defined source range never raise a peripheral trigger, so a
    // prohibited setting stays harmless.
    assign src = trigger_source_select[ch];
    assign periph = (src >= dma_pkg::SRC_MIN) & (src <= dma_pkg::SRC_MAX)
                    & trig_vec_in[src];
    // The software trigger is a strobe; it is never stored, so it reads zero.
    assign software_trigger[ch] = wr & (idx == I_MODE) & pstrb_in[0]
                                  & pwdata_in[dma_pkg::MODE_TRIG];
    assign trig = channel_enable_flag[ch] & transfer_pending_flag[ch]
                  & (software_trigger[ch] | periph);
    // Hold keeps a latched request waiting without losing it.
    assign ready[ch] = req[ch] & ~hold_select[ch] & channel_enable_flag[ch]
                       & transfer_pending_flag[ch];

    // SFR address is byte-wide and untouched by transfers.
    // Only lane 0 reaches it; a write on the upper lane leaves it unchanged.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        sfr_address_reg[ch] <= dma_pkg::SFR_RST;
      end else if (wr & (idx == I_SFR) & pstrb_in[0] & ~transfer_pending_flag[ch]) begin
        sfr_address_reg[ch] <= pwdata_in[7:0];
      end
    end

    // RAM address steps after each item and keeps its value on abort.
    // The step outranks a bus write, which a pending run refuses anyway.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        ram_address_reg[ch] <= dma_pkg::RAM_RST;
      end else if (mine) begin
        ram_address_reg[ch] <= ram_address_reg[ch] + (item_size_select[ch] ?
                               dma_pkg::STEP_WORD : dma_pkg::STEP_BYTE);
      end else if (wr & (idx == I_RAM) & ~transfer_pending_flag[ch]) begin
        if (pstrb_in[0]) begin
          ram_address_reg[ch][7:0] <= pwdata_in[7:0];
        end
        if (pstrb_in[1]) begin
          ram_address_reg[ch][15:8] <= pwdata_in[15:8];
        end
      end
    end

    // Count wraps from zero to 3FF, so a written zero yields 1024 items.
    // An abort stops further grants, so the count freezes where it stands.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        transfer_count_reg[ch] <= dma_pkg::CNT_RST;
      end else if (mine) begin
        transfer_count_reg[ch] <= transfer_count_reg[ch] - dma_pkg::CNT_LAST;
      end else if (wr & (idx == I_CNT) & ~transfer_pending_flag[ch]) begin
        if (pstrb_in[0]) begin
          transfer_count_reg[ch][7:0] <= pwdata_in[7:0];
        end
        if (pstrb_in[1]) begin
          transfer_count_reg[ch][9:8] <= pwdata_in[9:8]; // Upper bits are dropped.
        end
      end
    end

    // Mode fields may only change while no run is pending.
    // The hold bit stays writable so that software can release a held request.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        direction_select[ch] <= 1'b0;
        item_size_select[ch] <= 1'b0;
        hold_select[ch] <= 1'b0;
        trigger_source_select[ch] <= dma_pkg::SRC_RST;
      end else if (wr & (idx == I_MODE) & pstrb_in[0] & ~transfer_pending_flag[ch]) begin
        direction_select[ch] <= pwdata_in[dma_pkg::MODE_DIR];
        item_size_select[ch] <= pwdata_in[dma_pkg::MODE_SIZE];
        hold_select[ch] <= pwdata_in[dma_pkg::MODE_HOLD];
        trigger_source_select[ch] <= pwdata_in[3:0];
      end else if (wr & (idx == I_MODE) & pstrb_in[0]) begin
        hold_select[ch] <= pwdata_in[dma_pkg::MODE_HOLD]; // Releasing a hold is always allowed.
      end
    end

    // A software write of one beats the hardware clear in the same cycle.
    // Enable only changes while no run is pending, so only clearing pending cuts a run off.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        channel_enable_flag[ch] <= 1'b0;
        transfer_pending_flag[ch] <= 1'b0;
      end else if (wr & (idx == I_OP) & pstrb_in[0]) begin
        transfer_pending_flag[ch] <= pwdata_in[dma_pkg::OP_PEND];
        if (~transfer_pending_flag[ch]) begin
          channel_enable_flag[ch] <= pwdata_in[dma_pkg::OP_EN];
        end
      end else if (last) begin
        transfer_pending_flag[ch] <= 1'b0;
      end
    end

    // Trigger latch; a new trigger wins over the clear on grant.
    // A trigger that arrives while a request is latched merges with it, so
    // pulses faster than the item rate lose items.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        req[ch] <= 1'b0;
      end else if (trig) begin
        req[ch] <= 1'b1;
      end else if (~transfer_pending_flag[ch] | served) begin
        req[ch] <= 1'b0;
      end
    end

    // Completion pulse only for a run that ended by count, not by abort.
    // It is registered, so it follows the last write cycle by one edge.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        done_irq_out[ch] <= 1'b0;
      end else begin
        done_irq_out[ch] <= last & transfer_pending_flag[ch]
                            & ~(wr & (idx == I_OP) & pstrb_in[0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Item sequencer: idle, read cycle, write cycle.
  // Both channels share it, which is why their items never overlap in memory.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= dma_pkg::ST_IDLE;
    end else begin
      case (state)
        // Wait for a ready channel.
        dma_pkg::ST_IDLE: begin
          if (grant) begin
            state <= dma_pkg::ST_READ;
          end
        end
        // One read cycle, then one write cycle.
        dma_pkg::ST_READ: begin
          state <= dma_pkg::ST_WRITE;
        end
        // The write cycle returns to idle, so each grant costs one idle cycle.
        dma_pkg::ST_WRITE: begin
          state <= dma_pkg::ST_IDLE;
        end
        // An unused code falls back to idle rather than blocking every later grant.
        default: begin
          state <= dma_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // The served channel is remembered for the whole item.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cur <= 1'b0;
    end else if (grant) begin
      cur <= winner;
    end
  end

  // The source answers combinationally, so its data is taken at the read edge.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      item_data <= 16'h0000;
    end else if (state == dma_pkg::ST_READ) begin
      item_data <= mem_rdata_in;
    end
  end

  // Address forming; wide items force even addresses on both sides.
  // The upper bits are constants, so no address outside the two spaces forms.
  logic [19:0] sfr_full;
  logic [19:0] ram_full;
  logic wide;
  assign wide = item_size_select[cur];
  assign sfr_full = {dma_pkg::SFR_BASE, sfr_address_reg[cur][7:1],
                     sfr_address_reg[cur][0] & ~wide};
  assign ram_full = {dma_pkg::RAM_BASE, ram_address_reg[cur][15:1],
                     ram_address_reg[cur][0] & ~wide};

  // Only SFR and RAM addresses leave the block during an item.
  // Outputs rest at zero between items, so a stale address never looks live.
  always_comb begin
    mem_read_out = (state == dma_pkg::ST_READ);
    mem_write_out = (state == dma_pkg::ST_WRITE);
    mem_wide_out = wide & (mem_read_out | mem_write_out);
    mem_wdata_out = mem_write_out ? item_data : 16'h0000;
    cpu_stall_out = mem_read_out | mem_write_out;
    if (mem_read_out) begin
      mem_addr_out = direction_select[cur] ? ram_full : sfr_full;
    end else if (mem_write_out) begin
      mem_addr_out = direction_select[cur] ? sfr_full : ram_full;
    end else begin
      mem_addr_out = 20'h00000;
    end
  end
endmodule : sfr_ram_dma

/* File: tb/sfr_ram_dma_props.sv */
// Purpose: Port checker for the transfer engine.
// Assumes: One clock; reset is synchronous and active high.
// Notes: Bound to every engine instance.
`timescale 1ns/1ns
module sfr_ram_dma_props (
  input wire logic ref_clk_in, // Clock.
  input wire logic rst_in, // Reset.
  input wire logic psel_in, // Select.
  input wire logic penable_in, // Enable.
  input wire logic pready_out, // Ready.
  input wire logic pslverr_out, // Error.
  input wire logic [19:0] mem_addr_out, // Address.
  input wire logic mem_read_out, // Read.
  input wire logic mem_write_out, // Write.
  input wire logic mem_wide_out, // Wide item.
  input wire logic [15:0] mem_wdata_out, // Write data.
  input wire logic [15:0] mem_rdata_in, // Read data.
  input wire logic cpu_stall_out, // Stall.
  input wire logic [1:0] done_irq_out // Done.
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // Bus answers after one wait state, for one cycle.
  a_apb_wait: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
    else $error("ready not after one wait state");
  a_ready_once: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  // Item cycles: a read, then a write, with the CPU held only then.
  a_read_write: assert property (mem_read_out |=> mem_write_out && cpu_stall_out)
    else $error("read not followed by stalled write");
  a_stall_item: assert property (cpu_stall_out |-> mem_read_out || mem_write_out)
    else $error("stall outside an item");
  a_even_wide: assert property (mem_wide_out && mem_write_out |-> !mem_addr_out[0])
    else $error("odd address on wide item");
  a_wide_data: assert property (mem_read_out && mem_wide_out |=>
    mem_wdata_out == $past(mem_rdata_in)) else $error("wide data not passed whole");
  a_done_after: assert property (|done_irq_out |->
    $past(mem_write_out) || $past(mem_write_out, 2)) else $error("done without item");
  a_space_only: assert property (mem_read_out |-> mem_addr_out[19:16] == 4'hF)
    else $error("address outside SFR and RAM");
endmodule : sfr_ram_dma_props
////////////////////////////////////////
bind sfr_ram_dma sfr_ram_dma_props chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .mem_addr_out(mem_addr_out), .mem_read_out(mem_read_out),
  .mem_write_out(mem_write_out), .mem_wide_out(mem_wide_out),
  .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
  .cpu_stall_out(cpu_stall_out), .done_irq_out(done_irq_out));

/* File: tb/mem_model.sv */
// Purpose: SFR and RAM space behind the engine's memory port.
// Assumes: Reads are answered in the cycle of the read strobe.
// Notes: Outside a read the data flips each cycle, so stale data never matches.
`timescale 1ns/1ns
module mem_model (
  input wire logic clk_in, // Clock.
  input wire logic rd_in, // Read strobe.
  input wire logic [19:0] addr_in, // Address.
  output logic [15:0] rdata_out // Read data.
);
  logic [15:0] noise = 16'h0F0F;
  // Idle pattern changes every cycle.
  always @(posedge clk_in) begin
    noise <= ~noise;
  end
  // Each location answers with a value derived from its address.
  assign rdata_out = rd_in ? (addr_in[15:0] ^ 16'h3C5A) : noise;
endmodule : mem_model

/* File: tb/tb_sfr_ram_dma_controller.sv */
// Purpose: Self-checking bench for the transfer engine.
// Assumes: Every wait ends within the watchdog span.
// Notes: Queues log each memory cycle the engine makes.
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_sfr_ram_dma_controller;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, perr, rd, wr, wide, stall;
  logic [21:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic qerr;
  logic [3:0] strb = 4'hF;
  logic [15:0] trig = '0, rdata, wdata;
  logic [19:0] addr;
  logic [1:0] done;
  logic [19:0] rq[$], wq[$];
  logic [15:0] wd[$];
  int fail_count = 0, n_compared = 0, dn0 = 0, dn1 = 0;
  always #50 clk = ~clk;
  sfr_ram_dma dut (.ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(strb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .trig_vec_in(trig),
    .mem_addr_out(addr), .mem_read_out(rd), .mem_write_out(wr), .mem_wide_out(wide),
    .mem_wdata_out(wdata), .mem_rdata_in(rdata), .cpu_stall_out(stall), .done_irq_out(done));
  mem_model mem (.clk_in(clk), .rd_in(rd), .addr_in(addr), .rdata_out(rdata));
  // Log memory cycles and completion pulses as they happen.
  always @(posedge clk) begin
    if (rd === 1'b1) rq.push_back(addr);
    if (wr === 1'b1) wq.push_back(addr);
    if (wr === 1'b1) wd.push_back(wdata);
    if (done[0] === 1'b1) dn0++;
    if (done[1] === 1'b1) dn1++;
  end
  ////////////////////////////////////////
  // One APB transfer; the request is held until ready is sampled high.
  task automatic apb(input logic w, input logic [19:0] i, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    qerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic chk_rd(input string n, input logic [19:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    `CHK(n, e, q)
  endtask : chk_rd
  // Enable first, then program while idle, then set pending.
  task automatic arm(input int c, input logic [7:0] s, input logic [15:0] r,
      input logic [9:0] n, input logic [7:0] m);
    apb(1'b1, dma_pkg::IDX_OP0 + 20'(c), 32'h80);
    apb(1'b1, dma_pkg::IDX_SFR0 + 20'(c), {24'h0, s}); // No port config address.
    apb(1'b1, dma_pkg::IDX_RAM0 + 20'(2 * c), {16'h0, r}); // Stays in RAM.
    apb(1'b1, dma_pkg::IDX_CNT0 + 20'(2 * c), {22'h0, n}); // Upper bits zero.
    apb(1'b1, dma_pkg::IDX_MODE0 + 20'(c), {24'h0, m});
    apb(1'b1, dma_pkg::IDX_OP0 + 20'(c), 32'h81);
    rq.delete();
    wq.delete();
    wd.delete();
    dn0 = 0;
    dn1 = 0;
  endtask : arm
  // Triggers wait long enough for two queued items to finish.
  task automatic swt(input int c, input logic [7:0] m);
    apb(1'b1, dma_pkg::IDX_MODE0 + 20'(c), {24'h0, m | 8'h80});
    repeat (10) @(posedge clk);
  endtask : swt
  task automatic pulse(input int b);
    @(posedge clk);
    trig <= 16'h0001 << b;
    @(posedge clk);
    trig <= 16'h0000;
    repeat (10) @(posedge clk);
  endtask : pulse
  ////////////////////////////////////////
  task automatic t_reset();
    logic [19:0] ids [6] = '{dma_pkg::IDX_SFR0, dma_pkg::IDX_SFR1, dma_pkg::IDX_RAM0,
      dma_pkg::IDX_RAM1, dma_pkg::IDX_CNT0, dma_pkg::IDX_CNT1};
    foreach (ids[k]) chk_rd("reset value", ids[k], 32'h0);
    apb(1'b0, 20'h00010, 32'h0);
    `CHK("unmapped error", 1'b1, qerr)
  endtask : t_reset
  task automatic t_byte();
    arm(0, 8'h21, 16'hFE10, 10'h002, 8'h00);
    swt(0, 8'h00);
    `CHK("one item", 1, rq.size())
    chk_rd("count left", dma_pkg::IDX_CNT0, 32'h1);
    swt(0, 8'h00);
    `CHK("sfr address", 20'hFFF21, rq[0])
    `CHK("sfr fixed", 20'hFFF21, rq[1])
    `CHK("first ram", 20'hFFE10, wq[0])
    `CHK("ram step", 20'hFFE11, wq[1])
    chk_rd("ram end", dma_pkg::IDX_RAM0, 32'hFE12);
    chk_rd("pending", dma_pkg::IDX_OP0, 32'h80);
    `CHK("done", 1, dn0)
  endtask : t_byte
  task automatic t_word();
    arm(1, 8'h43, 16'hFE20, 10'h001, 8'h6C);
    pulse(2);
    `CHK("other source", 0, rq.size())
    pulse(12);
    `CHK("ram read", 20'hFFE20, rq[0])
    `CHK("sfr even", 20'hFFF42, wq[0])
    `CHK("word data", 16'hC27A, wd[0])
    chk_rd("ram word", dma_pkg::IDX_RAM1, 32'hFE22);
    `CHK("done ch1", 1, dn1)
  endtask : t_word
  // A held request waits for release; byte lanes gate register writes.
  task automatic t_hold();
    arm(1, 8'h55, 16'hFE71, 10'h001, 8'h30);
    swt(1, 8'h30);
    `CHK("held", 0, rq.size())
    apb(1'b1, dma_pkg::IDX_MODE1, 32'h0);
    repeat (10) @(posedge clk);
    `CHK("released", 1, rq.size())
    `CHK("sfr word", 20'hFFF54, rq[0])
    `CHK("ram even", 20'hFFE70, wq[0])
    `CHK("sfr data", 16'hC30E, wd[0])
    chk_rd("ram odd step", dma_pkg::IDX_RAM1, 32'hFE73);
    `CHK("done held", 1, dn1)
    strb <= 4'h2;
    apb(1'b1, dma_pkg::IDX_RAM1, 32'h1200);
    apb(1'b1, dma_pkg::IDX_SFR1, 32'h77);
    strb <= 4'hF;
    chk_rd("ram high lane", dma_pkg::IDX_RAM1, 32'h1273);
    chk_rd("sfr lane0 only", dma_pkg::IDX_SFR1, 32'h55);
  endtask : t_hold
  task automatic t_abort();
    arm(0, 8'h10, 16'hFE40, 10'h005, 8'h00);
    apb(1'b1, dma_pkg::IDX_RAM0, 32'h1234);
    chk_rd("ram locked", dma_pkg::IDX_RAM0, 32'hFE40);
    apb(1'b1, dma_pkg::IDX_CNT0, 32'h9);
    chk_rd("count locked", dma_pkg::IDX_CNT0, 32'h5);
    swt(0, 8'h00);
    apb(1'b1, dma_pkg::IDX_OP0, 32'h80);
    swt(0, 8'h00);
    `CHK("stopped", 1, rq.size())
    chk_rd("ram kept", dma_pkg::IDX_RAM0, 32'hFE41);
    chk_rd("count kept", dma_pkg::IDX_CNT0, 32'h4);
    `CHK("no done", 0, dn0)
  endtask : t_abort
  task automatic t_prio_full();
    arm(0, 8'h01, 16'hFE50, 10'h001, 8'h02);
    arm(1, 8'h02, 16'hFE60, 10'h001, 8'h02);
    pulse(2);
    `CHK("ch0 first", 20'hFFF01, rq[0])
    `CHK("ch1 next", 20'hFFF02, rq[1])
    arm(0, 8'h30, 16'hFA00, 10'h000, 8'h03);
    repeat (1024) pulse(3);
    `CHK("items", 1024, rq.size())
    chk_rd("ram full", dma_pkg::IDX_RAM0, 32'hFE00);
    `CHK("done full", 1, dn0)
  endtask : t_prio_full
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Main sequence after sixteen reset cycles.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_byte();
    t_word();
    t_hold();
    t_abort();
    t_prio_full();
    give_verdict();
  end
  // Watchdog cuts a hang short; the full run needs about 12700 cycles.
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : tb_sfr_ram_dma_controller
